// >>> tshi_pkg.sv
`default_nettype none
// ---------------------------------------------------------------
// constants of the ternary search host interface
// ---------------------------------------------------------------
package tshi_pkg;
	// instruction bus layout
	localparam int INSTR_W = 11;
	localparam int DQ_W = 72;
	localparam int OP_LSB = 0;
	localparam int OP_MSB = 1;
	localparam int EXT_LSB = 9;
	localparam int EXT_MSB = 10;
	// operation codes in instruction[1:0]
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_SEARCH = 2'h2;
	localparam logic [1:0] OP_LEARN = 2'h3;
	// programmed access target in instruction[3:2]
	localparam int TGT_LSB = 2;
	localparam int TGT_MSB = 3;
	localparam logic [1:0] TGT_DATA = 2'h0;
	localparam logic [1:0] TGT_MASK = 2'h1;
	localparam logic [1:0] TGT_BOTH = 2'h2;
	localparam logic [1:0] TGT_GMASK = 2'h3;
	// programmed access address in instruction[10:4]
	localparam int PADDR_LSB = 4;
	localparam int PADDR_MSB = 10;
	// global mask index for searches in instruction[5:2]
	localparam int GMI_LSB = 2;
	localparam int GMI_MSB = 5;
	localparam int GMASK_EXT = 16;
	localparam int GMASK_LEGACY = 8;
	// occupancy marker of a 72-bit word
	localparam int OCC_BIT = 0;
	// entry width modes
	localparam logic [1:0] WM_72 = 2'h0;
	localparam logic [1:0] WM_144 = 2'h1;
	localparam logic [1:0] WM_288 = 2'h2;
	// register map, byte addresses on the AXI4-Lite port
	localparam int REG_AW = 8;
	localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [REG_AW-1:0] REG_STATUS = 8'h04;
	localparam logic [REG_AW-1:0] REG_HIT_INDEX = 8'h08;
	localparam logic [REG_AW-1:0] REG_SEARCH_COUNT = 8'h0C;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// status register fields
	localparam int ST_TABLE_FULL = 0;
	localparam int ST_LOCAL_FULL = 1;
	localparam int ST_EXT_MODE = 2;
	localparam int ST_LAST_HIT = 3;
	localparam int ST_DOUBLE_RATE = 4;
endpackage : tshi_pkg
`default_nettype wire

// >>> tshi_engine.sv
`default_nettype none
// Summary of operation
// - low two instruction bits pick operation
// - 00 read, 01 write, 10 search, 11 learn
// - act only while instruction_valid is high
// - entries hold data and per-bit mask
// - lowest matching address wins
// - entries 72, 144 or 288 bits wide
// - only global lowest winner drives sram
// - fixed latency before sram and hit outputs
// - bit 0 marks entry occupied
// - full when every entry occupied
// - inputs sampled once per operating cycle
// - outputs change on operating cycle edge
// - phase input divides double-rate clock
// - reset puts all state known
// - legacy mode ignores instruction bits 10:9
// - extended mode: sixteen global masks
// - extended mode: parallel data/mask write
// - dq carries data and key, address comes from instruction
// - acknowledge marks valid read data
// - end-of-transfer marks final burst word
// - hit flag only from global winner
module tshi_engine
	import tshi_pkg::*;
#(
	parameter int ENTRIES = 16,
	parameter int PIPE_LAT = 4,
	parameter int SRAM_W = 24
)(
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [REG_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [REG_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// clocking and straps
	input wire logic clock_rate_select,
	input wire logic phase_divider_input,
	input wire logic extended_mode_strap,
	// instruction and data bus
	input wire logic [INSTR_W-1:0] instruction,
	input wire logic instruction_valid,
	input wire logic [DQ_W-1:0] dq_in,
	output logic [DQ_W-1:0] dq_out,
	output logic dq_oe,
	output logic read_ack_out,
	output logic read_ack_oe,
	output logic burst_last_flag_out,
	output logic burst_last_flag_oe,
	output logic search_hit_flag_out,
	output logic search_hit_flag_oe,
	output logic search_hit_valid_out,
	output logic search_hit_valid_oe,
	// cascade
	input wire logic upstream_hit_in,
	output logic local_hit_out,
	input wire logic last_device,
	input wire logic upstream_full_in,
	output logic local_full_out,
	output logic table_full,
	output logic [SRAM_W-1:0] sram_addr,
	output logic sram_addr_oe
);
	localparam int IDX_W = $clog2(ENTRIES);

	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------
	// lowest set bit wins, location zero first
	function automatic logic [IDX_W-1:0] lowest_index(input logic [ENTRIES-1:0] vec);
		logic [IDX_W-1:0] idx;
		idx = '0;
		for (int i = ENTRIES - 1; i >= 0; i--)
		begin
			if (vec[i])
			begin
				idx = IDX_W'(i);
			end
		end
		return idx;
	endfunction : lowest_index

	// strip bits 10:9 unless the strap enables them
	function automatic logic [INSTR_W-1:0] legal_instr(input logic [INSTR_W-1:0] ins, input logic ext);
		logic [INSTR_W-1:0] r;
		r = ins;
		if (!ext)
		begin
			r[EXT_MSB:EXT_LSB] = 2'h0;
		end
		return r;
	endfunction : legal_instr

	// ---------------------------------------------------------------
	// operating cycle enable
	// ---------------------------------------------------------------
	logic div_toggle;
	logic op_en;
	logic ext_mode;
	logic [1:0] width_mode;

	// single-rate: own divider; double-rate: phase input divides the clock
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			div_toggle <= 1'b0;
		else
			div_toggle <= ~div_toggle;
	end
	assign op_en = clock_rate_select ? div_toggle : ~phase_divider_input;

	// strap caught while reset is held, constant afterwards
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ext_mode <= extended_mode_strap;
	end

	// ---------------------------------------------------------------
	// instruction decode
	// ---------------------------------------------------------------
	logic [INSTR_W-1:0] ins;
	logic take;
	logic [1:0] op;
	logic [1:0] tgt;
	logic [IDX_W-1:0] paddr;
	logic [3:0] gmi;

	assign ins = legal_instr(instruction, ext_mode);
	assign take = op_en & instruction_valid;
	assign op = ins[OP_MSB:OP_LSB];
	assign tgt = ins[TGT_MSB:TGT_LSB];
	assign paddr = IDX_W'(ins[PADDR_MSB:PADDR_LSB]);
	// legacy mode reaches only eight global masks
	assign gmi = ext_mode ? ins[GMI_MSB:GMI_LSB] : {1'b0, ins[GMI_MSB-1:GMI_LSB]};

	// ---------------------------------------------------------------
	// entry storage and match
	// ---------------------------------------------------------------
	logic [DQ_W-1:0] ent_data [ENTRIES];
	logic [DQ_W-1:0] ent_mask [ENTRIES];
	logic [DQ_W-1:0] gmask [GMASK_EXT];
	logic [DQ_W-1:0] last_key;
	logic [ENTRIES-1:0] word_hit;
	logic [ENTRIES-1:0] group_hit;
	logic [ENTRIES-1:0] occupied;
	logic [ENTRIES-1:0] free_vec;
	logic [ENTRIES+2:0] word_hit_pad;

	// zero padding keeps group selects in range; partial top groups never hit
	assign word_hit_pad = {3'h0, word_hit};

	// per-word ternary compare, then width grouping
	for (genvar g = 0; g < ENTRIES; g++)
	begin : g_match
		// mask bit set means do not care
		assign word_hit[g] = &(~(ent_data[g] ^ dq_in) | ent_mask[g] | gmask[gmi]);
		assign occupied[g] = ent_data[g][OCC_BIT];
		assign free_vec[g] = ~ent_data[g][OCC_BIT];
		always_comb
		begin
			case (width_mode)
				WM_144: group_hit[g] = (g % 2 == 0) && (&word_hit_pad[g +: 2]);
				WM_288: group_hit[g] = (g % 4 == 0) && (&word_hit_pad[g +: 4]);
				default: group_hit[g] = word_hit[g];
			endcase
		end
	end

	logic any_hit;
	logic [IDX_W-1:0] hit_idx;
	logic [IDX_W-1:0] free_idx;
	logic all_occupied;

	assign any_hit = |group_hit;
	assign hit_idx = lowest_index(group_hit);
	assign free_idx = lowest_index(free_vec);
	assign all_occupied = &occupied;

	// programmed writes, learns and search key capture
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < ENTRIES; i++)
			begin
				ent_data[i] <= '0;
				ent_mask[i] <= '0;
			end
			for (int i = 0; i < GMASK_EXT; i++)
				gmask[i] <= '0;
			last_key <= '0;
		end
		else if (take)
		begin
			case (op)
				OP_WRITE:
				begin
					// parallel write only exists in extended mode
					if (tgt == TGT_DATA || (tgt == TGT_BOTH && ext_mode))
						ent_data[paddr] <= dq_in;
					if (tgt == TGT_MASK || (tgt == TGT_BOTH && ext_mode))
						ent_mask[paddr] <= dq_in;
					if (tgt == TGT_GMASK)
						gmask[ins[PADDR_LSB+3:PADDR_LSB]] <= dq_in;
				end
				OP_SEARCH:
					last_key <= dq_in;
				OP_LEARN:
				begin
					// learn fills the first empty word with the last key
					if (!all_occupied)
					begin
						ent_data[free_idx] <= {last_key[DQ_W-1:OCC_BIT+1], 1'b1};
						ent_mask[free_idx] <= '0;
					end
				end
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// fixed-latency result pipeline
	// ---------------------------------------------------------------
	logic [PIPE_LAT-1:0] p_rd;
	logic [PIPE_LAT-1:0] p_wr;
	logic [PIPE_LAT-1:0] p_srch;
	logic [PIPE_LAT-1:0] p_hit;
	logic [DQ_W-1:0] p_data [PIPE_LAT];
	logic [IDX_W-1:0] p_idx [PIPE_LAT];

	// stages advance only on the operating cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			p_rd <= '0;
			p_wr <= '0;
			p_srch <= '0;
			p_hit <= '0;
			for (int i = 0; i < PIPE_LAT; i++)
			begin
				p_data[i] <= '0;
				p_idx[i] <= '0;
			end
		end
		else if (op_en)
		begin
			p_rd[0] <= take && op == OP_READ;
			p_wr[0] <= take && op == OP_WRITE;
			p_srch[0] <= take && op == OP_SEARCH;
			p_hit[0] <= take && op == OP_SEARCH && any_hit;
			p_data[0] <= (tgt == TGT_MASK) ? ent_mask[paddr] : ent_data[paddr];
			p_idx[0] <= hit_idx;
			for (int i = 1; i < PIPE_LAT; i++)
			begin
				p_rd[i] <= p_rd[i-1];
				p_wr[i] <= p_wr[i-1];
				p_srch[i] <= p_srch[i-1];
				p_hit[i] <= p_hit[i-1];
				p_data[i] <= p_data[i-1];
				p_idx[i] <= p_idx[i-1];
			end
		end
	end

	// downstream devices see our hit one stage before the output
	assign local_hit_out = p_hit[PIPE_LAT-1];

	// ---------------------------------------------------------------
	// output stage
	// ---------------------------------------------------------------
	logic ack_q;
	logic eot_q;
	logic hit_q;
	logic hitv_q;
	logic own_q;
	logic [DQ_W-1:0] dq_q;
	logic [SRAM_W-1:0] sram_q;
	logic winner;

	// global winner: we hit and nobody nearer location zero did
	assign winner = p_hit[PIPE_LAT-1] & ~upstream_hit_in;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ack_q <= 1'b0;
			eot_q <= 1'b0;
			hit_q <= 1'b0;
			hitv_q <= 1'b0;
			own_q <= 1'b0;
			dq_q <= '0;
			sram_q <= '0;
		end
		else if (op_en)
		begin
			ack_q <= p_rd[PIPE_LAT-1];
			// single-word transfers are bursts of one
			eot_q <= p_rd[PIPE_LAT-1] | p_wr[PIPE_LAT-1];
			hit_q <= winner;
			hitv_q <= p_srch[PIPE_LAT-1];
			// the last device answers a search nobody won
			own_q <= winner | (p_srch[PIPE_LAT-1] & last_device & ~upstream_hit_in);
			dq_q <= p_data[PIPE_LAT-1];
			if (winner)
				sram_q <= SRAM_W'(p_idx[PIPE_LAT-1]);
		end
	end

	// weak pulldowns hold ack and eot low while released
	assign dq_out = dq_q;
	assign dq_oe = ack_q;
	assign read_ack_out = ack_q;
	assign read_ack_oe = ack_q;
	assign burst_last_flag_out = eot_q;
	assign burst_last_flag_oe = eot_q;
	assign search_hit_flag_out = hit_q;
	assign search_hit_flag_oe = own_q;
	assign search_hit_valid_out = hitv_q;
	assign search_hit_valid_oe = own_q;
	assign sram_addr = sram_q;
	assign sram_addr_oe = hit_q;

	// full flag combines local occupancy with upstream devices
	assign local_full_out = all_occupied;
	assign table_full = all_occupied & upstream_full_in;

	// ---------------------------------------------------------------
	// axi4-lite register slave
	// ---------------------------------------------------------------
	logic aw_held;
	logic w_held;
	logic [REG_AW-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [IDX_W-1:0] last_hit_idx;
	logic last_hit;
	logic [31:0] search_count;

	assign s_axi_awready = ~aw_held;
	assign s_axi_wready = ~w_held;
	assign s_axi_arready = ~s_axi_rvalid;

	// address and data may arrive in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
		end
	end

	// write completes once both halves are in
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			width_mode <= CTRL_RESET;
		end
		else if (aw_held && w_held && !s_axi_bvalid)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= RESP_OKAY;
			case (aw_addr_q)
				REG_CTRL:
					if (w_strb_q[0])
						width_mode <= w_data_q[1:0];
				REG_STATUS, REG_HIT_INDEX, REG_SEARCH_COUNT: ;
				default:
					s_axi_bresp <= RESP_SLVERR;
			endcase
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// read answers one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr)
				REG_CTRL:
					s_axi_rdata <= {30'h0, width_mode};
				REG_STATUS:
				begin
					s_axi_rdata <= '0;
					s_axi_rdata[ST_TABLE_FULL] <= table_full;
					s_axi_rdata[ST_LOCAL_FULL] <= all_occupied;
					s_axi_rdata[ST_EXT_MODE] <= ext_mode;
					s_axi_rdata[ST_LAST_HIT] <= last_hit;
					s_axi_rdata[ST_DOUBLE_RATE] <= ~clock_rate_select;
				end
				REG_HIT_INDEX:
					s_axi_rdata <= 32'(last_hit_idx);
				REG_SEARCH_COUNT:
					s_axi_rdata <= search_count;
				default:
				begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// local search history for software
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			last_hit <= 1'b0;
			last_hit_idx <= '0;
			search_count <= '0;
		end
		else if (take && op == OP_SEARCH)
		begin
			last_hit <= any_hit;
			last_hit_idx <= hit_idx;
			search_count <= search_count + 32'h1;
		end
	end
endmodule : tshi_engine
`default_nettype wire

// >>> tshi_props.sv
`default_nettype none
// --------
// timing and drive checks at the engine ports
// --------
module tshi_props
	import tshi_pkg::*;
#(
	parameter int PIPE_LAT = 4
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clock_rate_select,
	input wire logic phase_divider_input,
	input wire logic [INSTR_W-1:0] instruction,
	input wire logic instruction_valid,
	input wire logic dq_oe,
	input wire logic read_ack_out,
	input wire logic burst_last_flag_out,
	input wire logic search_hit_flag_out,
	input wire logic search_hit_flag_oe,
	input wire logic search_hit_valid_out,
	input wire logic upstream_hit_in,
	input wire logic last_device,
	input wire logic upstream_full_in,
	input wire logic table_full,
	input wire logic sram_addr_oe
);
	localparam int LAT2 = 2 * PIPE_LAT;
	localparam int QUIET = LAT2 + 2;
	logic tog;
	logic take;
	logic [1:0] op;
	logic [7:0] idle;
	// mirror of the single-rate divider, cleared by the same reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tog <= 1'b0;
		else
			tog <= !tog;
	end
	// accepted instruction in either clock mode
	assign take = instruction_valid && (clock_rate_select ? tog : !phase_divider_input);
	assign op = instruction[OP_MSB:OP_LSB];
	// cycles since the last accepted instruction, saturating
	always_ff @(posedge aclk)
	begin
		if (!aresetn || take)
			idle <= 8'h00;
		else if (idle != 8'hFF)
			idle <= idle + 8'h01;
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_read_slot: assert property (take && op == OP_READ |-> ##[LAT2:LAT2] !read_ack_out ##1 read_ack_out [*2])
		else $error("read acknowledge off its slot");
	a_write_end: assert property (take && op == OP_WRITE |-> ##[LAT2:LAT2] !burst_last_flag_out ##1 burst_last_flag_out)
		else $error("write end flag off its slot");
	a_search_slot: assert property (take && op == OP_SEARCH |-> ##[LAT2:LAT2] !search_hit_valid_out ##1 search_hit_valid_out)
		else $error("hit valid off its slot");
	a_idle_quiet: assert property (idle > QUIET |-> !read_ack_out && !burst_last_flag_out && !search_hit_valid_out)
		else $error("result strobe without instruction");
	a_ack_drives_dq: assert property (read_ack_out |-> dq_oe)
		else $error("acknowledge without data drive");
	a_flag_qualified: assert property (search_hit_flag_out |-> search_hit_valid_out)
		else $error("hit flag without valid");
	a_nearer_wins: assert property (search_hit_flag_out |-> !$past(upstream_hit_in))
		else $error("hit flag despite nearer hit");
	a_shared_release: assert property (search_hit_flag_oe |->
		search_hit_flag_out || (last_device && !$past(upstream_hit_in)))
		else $error("flag driven while not selected");
	a_sram_winner: assert property (sram_addr_oe |-> search_hit_flag_oe && search_hit_valid_out)
		else $error("sram address driven by loser");
	a_full_chain: assert property (!upstream_full_in [*2] |-> !table_full)
		else $error("full while upstream not full");
endmodule : tshi_props
`default_nettype wire

// >>> tshi_host.sv
`default_nettype none
// --------
// host side of the instruction bus
// --------
module tshi_host
	import tshi_pkg::*;
(
	input wire logic aclk,
	input wire logic clock_rate_select,
	output logic phase_divider_input,
	output logic [INSTR_W-1:0] instruction,
	output logic instruction_valid,
	output logic [DQ_W-1:0] dq_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		phase_divider_input = 1'h0;
		instruction = '0;
		instruction_valid = 1'h0;
		dq_in = '0;
	end
	// board phase runs at half the aclk rate, grounded in single-rate mode
	always @(posedge aclk)
		phase_divider_input <= clock_rate_select ? 1'h0 : !phase_divider_input;
	// double-rate: held over one phase-low edge; single-rate: over two edges, one operating cycle
	task automatic issue(input logic [INSTR_W-1:0] cmd, input logic [DQ_W-1:0] data, input logic v);
		@(posedge aclk);
		if (!clock_rate_select && phase_divider_input !== 1'h1)
			@(posedge aclk);
		instruction <= {2'h0, cmd[8:0]};
		dq_in <= data;
		instruction_valid <= v;
		repeat (clock_rate_select ? 2 : 1) @(posedge aclk);
		instruction_valid <= 1'h0;
		// idle bus shows garbage, never a stale copy of the request
		instruction <= {2'h0, ~cmd[8:0]};
		dq_in <= ~data;
	endtask : issue
endmodule : tshi_host
`default_nettype wire

// >>> ternary_search_host_interface_tb.sv
`default_nettype none
module ternary_search_host_interface_tb
	import tshi_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [71:0] D1 = 72'h12_3456_789A_BCDE_F001;
	localparam logic [71:0] K = 72'hC3_0000_0000_0000_0F0F;
	localparam logic [71:0] L = 72'h0F_F000_0000_0000_0003;
	localparam logic [71:0] X = 72'h00_0000_0000_0000_0010;
	logic aclk, aresetn, clock_rate_select, phase_divider_input, extended_mode_strap, instruction_valid;
	logic [REG_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [INSTR_W-1:0] instruction;
	logic [DQ_W-1:0] dq_in, dq_out;
	logic dq_oe, read_ack_out, read_ack_oe, burst_last_flag_out, burst_last_flag_oe, sram_addr_oe;
	logic search_hit_flag_out, search_hit_flag_oe, search_hit_valid_out, search_hit_valid_oe;
	logic upstream_hit_in, local_hit_out, last_device, upstream_full_in, local_full_out, table_full;
	logic [23:0] sram_addr;
	int fails, num_checks;
	tshi_engine #(.ENTRIES(4)) tshi_engine_i (.*);
	tshi_host tshi_host_i (.*);
	// --------
	// clock and helpers
	// --------
	initial
	begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// a wait that used up its bound ends the run
	task automatic guard(input int n);
		if (n >= 40)
		begin
			fails++;
			print_verdict();
		end
	endtask : guard
	// learn and refused requests give no strobe, so they get a pipeline's worth of cycles
	task automatic run(input logic [INSTR_W-1:0] cmd, input logic [DQ_W-1:0] d, input logic v);
		int n;
		n = 0;
		tshi_host_i.issue(cmd, d, v);
		if (!v || cmd[1:0] == OP_LEARN)
			repeat (12) @(posedge aclk);
		else
		begin
			do
				@(posedge aclk);
			while (!(read_ack_out === 1'h1 || burst_last_flag_out === 1'h1 || search_hit_valid_out === 1'h1) && ++n < 40);
			guard(n);
		end
	endtask : run
	task automatic srch(input logic [DQ_W-1:0] key, input logic hit, input logic [23:0] idx);
		run({5'h0, 4'h0, OP_SEARCH}, key, 1'h1);
		check("hit valid", search_hit_valid_out, 1'h1);
		check("hit flag", search_hit_flag_out, hit);
		if (hit)
			check("index", sram_addr, idx);
	endtask : srch
	task automatic axi_wr(input logic [REG_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (s_axi_bvalid !== 1'h1 && ++n < 40);
		guard(n);
		s_axi_bready <= 1'h0;
		check("bresp", s_axi_bresp, er);
	endtask : axi_wr
	task automatic axi_rd(input logic [REG_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (s_axi_rvalid !== 1'h1 && ++n < 40);
		guard(n);
		s_axi_rready <= 1'h0;
		check("rresp", s_axi_rresp, er);
		if (er == RESP_OKAY)
			check("rdata", s_axi_rdata, d);
	endtask : axi_rd
	// --------
	// main sequence
	// --------
	initial
	begin
		aresetn = 1'h0;
		clock_rate_select = 1'h0;
		extended_mode_strap = 1'h0;
		last_device = 1'h1;
		upstream_hit_in = 1'h0;
		upstream_full_in = 1'h1;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		s_axi_awvalid = 1'h0;
		s_axi_wvalid = 1'h0;
		s_axi_bready = 1'h0;
		s_axi_arvalid = 1'h0;
		s_axi_rready = 1'h0;
		fails = 0;
		num_checks = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		check("local full", local_full_out, 1'h0);
		axi_rd(REG_STATUS, 32'h10, RESP_OKAY);
		$display("test reset done");
		// write, refused write, read back
		run({7'h1, TGT_DATA, OP_WRITE}, D1, 1'h1);
		check("write end", burst_last_flag_out, 1'h1);
		run({7'h1, TGT_DATA, OP_WRITE}, K, 1'h0);
		run({7'h1, TGT_DATA, OP_READ}, '0, 1'h1);
		check("ack", read_ack_out, 1'h1);
		check("read data", dq_out, D1);
		$display("test access done");
		// two equal entries, then a masked bit, then a miss
		run({7'h2, TGT_DATA, OP_WRITE}, K, 1'h1);
		run({7'h3, TGT_DATA, OP_WRITE}, K, 1'h1);
		srch(K, 1'h1, 24'h2);
		run({7'h1, TGT_MASK, OP_WRITE}, X, 1'h1);
		srch(D1 ^ X, 1'h1, 24'h1);
		srch(~K, 1'h0, 24'h0);
		upstream_hit_in <= 1'h1;
		srch(K, 1'h0, 24'h0);
		check("flag drive", search_hit_flag_oe, 1'h0);
		upstream_hit_in <= 1'h0;
		$display("test search done");
		// learn takes the only empty word, which fills the table
		srch(L, 1'h0, 24'h0);
		run({9'h0, OP_LEARN}, '0, 1'h1);
		run({7'h0, TGT_DATA, OP_READ}, '0, 1'h1);
		check("learned", dq_out, L);
		check("local full", local_full_out, 1'h1);
		check("table full", table_full, 1'h1);
		axi_rd(REG_STATUS, 32'h13, RESP_OKAY);
		upstream_full_in <= 1'h0;
		repeat (2) @(posedge aclk);
		check("cascade full", table_full, 1'h0);
		upstream_full_in <= 1'h1;
		$display("test learn done");
		// width mode, search count and an unmapped place
		axi_wr(REG_CTRL, {30'h0, WM_144}, RESP_OKAY);
		axi_rd(REG_CTRL, {30'h0, WM_144}, RESP_OKAY);
		axi_rd(REG_SEARCH_COUNT, 32'h5, RESP_OKAY);
		// a lone matching word and an incomplete group must not hit in wide modes
		srch(L, 1'h0, 24'h0);
		axi_wr(REG_CTRL, {30'h0, WM_288}, RESP_OKAY);
		srch(K, 1'h0, 24'h0);
		axi_wr(8'h10, 32'h0, RESP_SLVERR);
		axi_rd(8'h10, 32'h0, RESP_SLVERR);
		$display("test registers done");
		// single-rate clocking: phase grounded, the divider paces the bus
		clock_rate_select <= 1'h1;
		run({7'h2, TGT_DATA, OP_READ}, '0, 1'h1);
		check("single-rate ack", read_ack_out, 1'h1);
		check("single-rate data", dq_out, K);
		axi_rd(REG_STATUS, 32'h3, RESP_OKAY);
		$display("test single-rate done");
		print_verdict();
	end
endmodule : ternary_search_host_interface_tb
bind tshi_engine tshi_props #(.PIPE_LAT(PIPE_LAT)) tshi_props_i (.*);
`default_nettype wire
